// File: pkg/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

    // ************************************************************
    // Register map (byte addresses on the bus)
    // ************************************************************
    localparam logic [3:0] OFS_SC1      = 4'h0;   // First status/control
    localparam logic [3:0] OFS_SC2      = 4'h4;   // Second status/control
    localparam logic [3:0] OFS_RESLO    = 4'h8;   // Result low byte
    localparam logic [3:0] OFS_RESHI    = 4'hc;   // Result high nibble

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_DONE   = 7;                 // Done flag in first reg
    localparam int BIT_IEN    = 6;                 // Interrupt enable
    localparam int BIT_CONT   = 5;                 // Continuous enable
    localparam int BIT_ACTIVE = 7;                 // Active flag in second reg
    localparam int BIT_TRIG   = 6;                 // Trigger select
    localparam int BIT_CMPEN  = 5;                 // Compare enable
    localparam int BIT_CMPGE  = 4;                 // Compare sense

    // ************************************************************
    // Channel codes and reset values
    // ************************************************************
    localparam logic [4:0] CH_LAST_EXT  = 5'h1b;   // Input 27
    localparam logic [4:0] CH_RESERVED  = 5'h1c;   // Reserved code
    localparam logic [4:0] CH_REF_HIGH  = 5'h1d;   // High reference
    localparam logic [4:0] CH_REF_LOW   = 5'h1e;   // Low reference
    localparam logic [4:0] CH_OFF       = 5'h1f;   // Converter off
    localparam logic [7:0] RST_SC1      = 8'h1f;   // Off after reset
    localparam logic [7:0] RST_SC2      = 8'h00;
    localparam int         CONV_CYCLES  = 16;      // Conversion length

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_DONE = 2'b11
    } conv_state_t;

    typedef struct packed {
        logic       doneIen;
        logic       contEn;
        logic [4:0] channel;
    } sc1_ctl_t;

    typedef struct packed {
        logic trigSel;
        logic cmpEn;
        logic cmpGe;
    } sc2_ctl_t;

endpackage

// File: hdl/adc_conversion_control.sv
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
// Operation
// - Write to first register aborts, restarts unless off or hardware trigger selected
// - Done flag sets per conversion, compare-gated
// - Done flag clears on first write, low read
// - Interrupt when done set with enable high
// - Single mode: one conversion per trigger
// - Continuous mode repeats after first trigger
// - Five-bit field selects among 28 channels
// - Channel codes decode to inputs and references
// - All-ones channel switches off, no extra conversion
// - Single mode enters low power after conversion
// - Active flag set at start, cleared at end/abort
// - Trigger select picks software or hardware start
// - Bit five enables compare function
// - Bit four picks less-than or greater-equal
// - Failed compare leaves result registers unchanged
// - Counter match triggers conversion when selected
module adc_conversion_control #(
    parameter int CONV_LEN = adc_ctrl_pkg::CONV_CYCLES   // Cycles per conversion
) (
    input  wire logic        mclk,          // Bus clock
    input  wire logic        arst_n,        // Async reset, active low
    input  wire logic        wb_cyc_i,      // Wishbone cycle
    input  wire logic        wb_stb_i,      // Wishbone strobe
    input  wire logic        wb_we_i,       // Write enable
    input  wire logic [3:0]  wb_adr_i,      // Byte address
    input  wire logic [3:0]  wb_sel_i,      // Byte selects
    input  wire logic [31:0] wb_dat_i,      // Write data
    output logic      [31:0] wb_dat_o,      // Read data
    output logic             wb_ack_o,      // Acknowledge
    input  wire logic        hardware_trigger_in, // Counter match pulse, async
    input  wire logic [11:0] conv_result,   // Converter result
    input  wire logic [11:0] compare_value, // Compare threshold
    output logic [4:0]       analog_select, // Selected analog input
    output logic             high_reference,// High reference selected
    output logic             low_reference, // Low reference selected
    output logic             conv_power,    // Converter powered
    output logic             conv_start,    // One-cycle start pulse
    output logic             irq            // Done interrupt, level
);

    // ************************************************************
    // Registers
    // ************************************************************
    adc_ctrl_pkg::sc1_ctl_t    sc1_r,    sc1_nxt;     // First register control
    adc_ctrl_pkg::sc2_ctl_t    sc2_r,    sc2_nxt;     // Second register control
    adc_ctrl_pkg::conv_state_t state_r,  state_nxt;   // Sequencer
    logic                      done_r,   done_nxt;    // Done flag
    logic                      armed_r,  armed_nxt;   // Continuous armed
    logic [7:0]                cnt_r,    cnt_nxt;     // Conversion timer
    logic [11:0]               res_r,    res_nxt;     // Held result
    logic [31:0]               dat_r,    dat_nxt;     // Read data
    logic                      ack_r,    ack_nxt;     // Ack
    logic                      start_r,  start_nxt;   // Start pulse
    logic [4:0]                sel_r,    sel_nxt;     // Analog mux
    logic                      refh_r,   refh_nxt;
    logic                      refl_r,   refl_nxt;
    logic                      pwr_r,    pwr_nxt;
    logic                      irq_r,    irq_nxt;
    logic [2:0]                trgSync_r;             // Trigger synchroniser

    // ************************************************************
    // Helpers
    // ************************************************************
    // Compare result in chosen sense
    // The compare value comes from outside, already settled on this clock
    // Only the greater-equal sense includes equality
    function automatic logic cmp_true(input logic [11:0] r, input logic [11:0] c, input logic ge);
        cmp_true = ge ? (r >= c) : (r < c);
    endfunction

    logic busReq;       // New request this cycle
    logic wrSc1;        // Write to first register
    logic wrSc2;        // Write to second register
    logic rdLow;        // Read of low result
    logic hwEdge;       // Hardware trigger rising edge
    logic finish;       // Conversion ends this cycle
    logic cmpOk;        // Done condition met

    assign busReq = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wrSc1  = busReq & wb_we_i & wb_sel_i[0] & (wb_adr_i == adc_ctrl_pkg::OFS_SC1);
    assign wrSc2  = busReq & wb_we_i & wb_sel_i[0] & (wb_adr_i == adc_ctrl_pkg::OFS_SC2);
    assign rdLow  = busReq & ~wb_we_i & (wb_adr_i == adc_ctrl_pkg::OFS_RESLO);
    assign hwEdge = trgSync_r[1] & ~trgSync_r[2];
    assign finish = (state_r == adc_ctrl_pkg::ST_CONV) && (cnt_r == 8'(CONV_LEN - 1));
    assign cmpOk  = ~sc2_r.cmpEn | cmp_true(conv_result, compare_value, sc2_r.cmpGe);

    // ************************************************************
    // Trigger synchroniser
    // ************************************************************
    // Two stages plus an edge-history stage
    // The first stage may go metastable, so only the second stage reads it
    // Stages two and three together form the rising-edge detector
    // Reset value matches the idle low level, so no false edge after reset
    // A level held high starts only one sequence, however long it stays
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            trgSync_r <= 3'h0;
        end else begin
            trgSync_r <= {trgSync_r[1:0], hardware_trigger_in};
        end
    end

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        logic trig;
        trig      = 1'b0;
        sc1_nxt   = sc1_r;
        sc2_nxt   = sc2_r;
        state_nxt = state_r;
        done_nxt  = done_r;
        armed_nxt = armed_r;
        cnt_nxt   = cnt_r;
        res_nxt   = res_r;
        start_nxt = 1'b0;
        ack_nxt   = busReq;
        dat_nxt   = 32'h0;
        // Register writes
        // Only byte lane zero carries the eight-bit registers
        // Flag bits in the written byte are read-only and dropped
        if (wrSc1) begin
            sc1_nxt = adc_ctrl_pkg::sc1_ctl_t'(wb_dat_i[6:0]);
        end
        if (wrSc2) begin
            sc2_nxt = {wb_dat_i[adc_ctrl_pkg::BIT_TRIG], wb_dat_i[adc_ctrl_pkg::BIT_CMPEN],
                       wb_dat_i[adc_ctrl_pkg::BIT_CMPGE]};
        end
        // Read data
        if (busReq && !wb_we_i) begin
            case (wb_adr_i)
                adc_ctrl_pkg::OFS_SC1:   dat_nxt = {24'h0, done_r, sc1_r};
                adc_ctrl_pkg::OFS_SC2:   dat_nxt = {24'h0, state_r == adc_ctrl_pkg::ST_CONV,
                                                    sc2_r, 4'h0};
                adc_ctrl_pkg::OFS_RESLO: dat_nxt = {24'h0, res_r[7:0]};
                adc_ctrl_pkg::OFS_RESHI: dat_nxt = {28'h0, res_r[11:8]};
                default:                 dat_nxt = 32'h0;
            endcase
        end
        // Sequencer
        // Idle holds the timer at zero, ready for the next start
        // Conversion counts up to the configured length minus one
        // Done lasts one cycle and may chain into the next conversion
        // A failed compare keeps the held result and the flag untouched
        case (state_r)
            adc_ctrl_pkg::ST_IDLE: begin
                cnt_nxt = 8'h0;
            end
            adc_ctrl_pkg::ST_CONV: begin
                cnt_nxt = cnt_r + 8'h1;
                if (finish) begin
                    if (cmpOk) begin
                        done_nxt = 1'b1;
                        res_nxt  = conv_result;
                    end
                    state_nxt = adc_ctrl_pkg::ST_DONE;
                end
            end
            adc_ctrl_pkg::ST_DONE: begin
                cnt_nxt   = 8'h0;
                state_nxt = adc_ctrl_pkg::ST_IDLE;
                if (sc1_r.contEn && armed_r && sc1_r.channel != adc_ctrl_pkg::CH_OFF) begin
                    trig = 1'b1;
                end
            end
            default: state_nxt = adc_ctrl_pkg::ST_IDLE;
        endcase
        // Hardware trigger source
        // An edge during a conversion restarts it from the beginning
        // The edge also arms back-to-back operation when continuous
        if (sc2_r.trigSel && hwEdge && sc1_r.channel != adc_ctrl_pkg::CH_OFF) begin
            trig      = 1'b1;
            armed_nxt = 1'b1;
        end
        // Software write aborts and restarts
        // The write always ends the running conversion first
        // With hardware triggering selected it only disarms
        // The off code never starts, which stops continuous runs cleanly
        if (wrSc1) begin
            state_nxt = adc_ctrl_pkg::ST_IDLE;
            armed_nxt = 1'b0;
            trig      = 1'b0;
            if (wb_dat_i[4:0] != adc_ctrl_pkg::CH_OFF) begin
                if (!sc2_r.trigSel) begin
                    trig      = 1'b1;
                    armed_nxt = 1'b1;
                end
            end
        end
        if (trig) begin
            state_nxt = adc_ctrl_pkg::ST_CONV;
            cnt_nxt   = 8'h0;
            start_nxt = 1'b1;
        end
        // Clear on write or low read; completion wins
        // A write still wins, since it aborts and so owns the flag
        if ((wrSc1 || rdLow) && !(finish && cmpOk && !wrSc1)) begin
            done_nxt = 1'b0;
        end
    end

    // ************************************************************
    // Output decode
    // ************************************************************
    // Mux select follows the stored channel one cycle later
    // Reference codes raise their own select, the mux then rests at zero
    // Power and interrupt look ahead so they change with the state
    always_comb begin
        sel_nxt  = (sc1_r.channel <= adc_ctrl_pkg::CH_LAST_EXT) ? sc1_r.channel : 5'h0;
        refh_nxt = sc1_r.channel == adc_ctrl_pkg::CH_REF_HIGH;
        refl_nxt = sc1_r.channel == adc_ctrl_pkg::CH_REF_LOW;
        pwr_nxt  = (state_nxt == adc_ctrl_pkg::ST_CONV) && (sc1_nxt.channel != adc_ctrl_pkg::CH_OFF);
        irq_nxt  = done_nxt & sc1_nxt.doneIen;
    end

    // ************************************************************
    // State registers
    // ************************************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            // Converter off and idle after reset
            sc1_r   <= adc_ctrl_pkg::sc1_ctl_t'(adc_ctrl_pkg::RST_SC1[6:0]);
            sc2_r   <= adc_ctrl_pkg::sc2_ctl_t'(3'h0);
            state_r <= adc_ctrl_pkg::ST_IDLE;
            done_r  <= 1'b0;
            armed_r <= 1'b0;
            cnt_r   <= 8'h0;
            res_r   <= 12'h0;
            dat_r   <= 32'h0;
            ack_r   <= 1'b0;
            start_r <= 1'b0;
            sel_r   <= 5'h0;
            refh_r  <= 1'b0;
            refl_r  <= 1'b0;
            pwr_r   <= 1'b0;
            irq_r   <= 1'b0;
        end else begin
            sc1_r   <= sc1_nxt;
            sc2_r   <= sc2_nxt;
            state_r <= state_nxt;
            done_r  <= done_nxt;
            armed_r <= armed_nxt;
            cnt_r   <= cnt_nxt;
            res_r   <= res_nxt;
            dat_r   <= dat_nxt;
            ack_r   <= ack_nxt;
            start_r <= start_nxt;
            sel_r   <= sel_nxt;
            refh_r  <= refh_nxt;
            refl_r  <= refl_nxt;
            pwr_r   <= pwr_nxt;
            irq_r   <= irq_nxt;
        end
    end

    // Every output is a register, never a gate
    assign wb_dat_o       = dat_r;
    assign wb_ack_o       = ack_r;
    assign conv_start     = start_r;
    assign analog_select  = sel_r;
    assign high_reference = refh_r;
    assign low_reference  = refl_r;
    assign conv_power     = pwr_r;
    assign irq            = irq_r;

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_conv_end;
        state_r == adc_ctrl_pkg::ST_CONV ##1 state_r == adc_ctrl_pkg::ST_DONE;
    endsequence

    a_write_restarts: assert property (@(posedge mclk) disable iff (!arst_n)
        wrSc1 && wb_dat_i[4:0] != adc_ctrl_pkg::CH_OFF && !sc2_r.trigSel |=> start_r)
        else $error("write did not restart conversion");
    a_off_no_start: assert property (@(posedge mclk) disable iff (!arst_n)
        wrSc1 && wb_dat_i[4:0] == adc_ctrl_pkg::CH_OFF |=> !start_r && !pwr_r)
        else $error("off code started conversion");
    a_done_sets: assert property (@(posedge mclk) disable iff (!arst_n)
        finish && !sc2_r.cmpEn && !wrSc1 |=> done_r)
        else $error("done flag not set");
    a_done_clears: assert property (@(posedge mclk) disable iff (!arst_n)
        wrSc1 |=> !done_r)
        else $error("done flag not cleared");
    a_irq_level: assert property (@(posedge mclk) disable iff (!arst_n)
        irq_r == (done_r && sc1_r.doneIen))
        else $error("interrupt mismatch");
    a_single_stop: assert property (@(posedge mclk) disable iff (!arst_n)
        s_conv_end ##0 !sc1_r.contEn && !hwEdge && !wrSc1 |=> state_r == adc_ctrl_pkg::ST_IDLE)
        else $error("single mode repeated");
    a_failed_hold: assert property (@(posedge mclk) disable iff (!arst_n)
        finish && !cmpOk |=> res_r == $past(res_r))
        else $error("result changed on failed compare");
    a_conv_length: assert property (@(posedge mclk) disable iff (!arst_n)
        start_r && !wrSc1 && !hwEdge |-> (state_r == adc_ctrl_pkg::ST_CONV)[*2])
        else $error("conversion ended early");
    a_hw_trigger: assert property (@(posedge mclk) disable iff (!arst_n)
        hwEdge && sc2_r.trigSel && sc1_r.channel != adc_ctrl_pkg::CH_OFF && !wrSc1 |=> start_r)
        else $error("hardware trigger ignored");

    // ************************************************************
    // Further checks
    // ************************************************************
    // Done cycle of a run allowed to chain into the next one
    sequence s_chain_ready;
        sc1_r.contEn && armed_r && sc1_r.channel != adc_ctrl_pkg::CH_OFF && !wrSc1;
    endsequence

    // Continuous runs restart straight after the done cycle
    a_chain_restart: assert property (@(posedge mclk) disable iff (!arst_n)
        s_conv_end ##0 s_chain_ready |=> start_r)
        else $error("continuous run did not restart");

    // A write that does not restart leaves no conversion running
    a_abort_idle: assert property (@(posedge mclk) disable iff (!arst_n)
        wrSc1 && (wb_dat_i[4:0] == adc_ctrl_pkg::CH_OFF || sc2_r.trigSel) |=> state_r != adc_ctrl_pkg::ST_CONV)
        else $error("aborted conversion still active");

    // Reading the low result clears the flag unless a result lands
    a_low_read_clr: assert property (@(posedge mclk) disable iff (!arst_n)
        rdLow && !finish |=> !done_r)
        else $error("low read did not clear done flag");

    // A failed compare never raises the flag
    a_cmp_fail_flag: assert property (@(posedge mclk) disable iff (!arst_n)
        finish && !cmpOk && !done_r |=> !done_r)
        else $error("done flag set on failed compare");

    // Converter powered only while converting
    a_power_idle: assert property (@(posedge mclk) disable iff (!arst_n)
        state_r != adc_ctrl_pkg::ST_CONV |-> !pwr_r)
        else $error("converter powered while idle");

    // The edge detector gives one-cycle pulses only
    a_edge_once: assert property (@(posedge mclk) disable iff (!arst_n)
        hwEdge |=> !hwEdge)
        else $error("trigger edge lasted two cycles");

    // Reference selects follow the stored channel code
    a_ref_decode: assert property (@(posedge mclk) disable iff (!arst_n)
        1'b1 |=> refh_r == ($past(sc1_r.channel) == adc_ctrl_pkg::CH_REF_HIGH) &&
                 refl_r == ($past(sc1_r.channel) == adc_ctrl_pkg::CH_REF_LOW))
        else $error("reference select mismatch");

    // Mux select shows external inputs only
    a_sel_decode: assert property (@(posedge mclk) disable iff (!arst_n)
        1'b1 |=> sel_r == (($past(sc1_r.channel) <= adc_ctrl_pkg::CH_LAST_EXT) ? $past(sc1_r.channel) : 5'h0))
        else $error("analog select mismatch");

    // Active flag reads high while a conversion runs
    a_active_read: assert property (@(posedge mclk) disable iff (!arst_n)
        busReq && !wb_we_i && wb_adr_i == adc_ctrl_pkg::OFS_SC2 && state_r == adc_ctrl_pkg::ST_CONV
        |=> wb_dat_o[adc_ctrl_pkg::BIT_ACTIVE])
        else $error("active flag not shown");

endmodule // adc_conversion_control

// File: bench/adc_conversion_control_tb_top.sv
`timescale 1ns/1ps
module adc_conversion_control_tb_top;
    // ************************************************************
    // Clock, reset and design ports
    // ************************************************************
    localparam int CLEN = 8;                       // Shortened conversion
    logic        mclk        = 1'b0;               // Bus clock
    logic        arst_n      = 1'b0;               // Reset, active low
    logic        cyc         = 1'b0;               // Bus cycle
    logic        stb         = 1'b0;               // Bus strobe
    logic        we          = 1'b0;               // Bus direction
    logic [3:0]  adr         = 4'h0;               // Bus address
    logic [3:0]  sel         = 4'h0;               // Byte lanes
    logic [31:0] wdat        = 32'h0;              // Write data
    logic [31:0] rdat;                             // Read data
    logic        ack;                              // Acknowledge
    logic        trig        = 1'b0;               // Hardware trigger
    logic [11:0] res         = 12'h0;              // Converter result
    logic [11:0] cmpv        = 12'h0;              // Compare value
    logic [4:0]  asel;                             // Selected input
    logic        refHi;                            // High reference
    logic        refLo;                            // Low reference
    logic        power;                            // Converter powered
    logic        start;                            // Start pulse
    logic        irq;                              // Interrupt
    int          mismatches  = 0;                  // Failed checks
    int          comparisons = 0;                  // All checks
    int          starts      = 0;                  // Start pulses seen
    int          seed        = 32'h3ac5cc90;       // Random seed
    logic [31:0] expQ[$];                          // Expected read data
    logic [31:0] mskQ[$];                          // Read masks

    // Half period of 20 ns
    always #20 mclk = ~mclk;

    adc_conversion_control #(.CONV_LEN(CLEN)) DUT (
        .mclk(mclk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .hardware_trigger_in(trig), .conv_result(res), .compare_value(cmpv),
        .analog_select(asel), .high_reference(refHi), .low_reference(refLo),
        .conv_power(power), .conv_start(start), .irq(irq));

    // ************************************************************
    // Checking and closing
    // ************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Read results taken off the queue as they appear
    always @(posedge mclk) begin
        if (ack === 1'b1 && we === 1'b0 && expQ.size() > 0) chk(rdat & mskQ.pop_front(), expQ.pop_front());
    end

    // Count start pulses
    always @(posedge mclk) begin
        if (start === 1'b1) starts++;
    end

    // ************************************************************
    // Bus and wait tasks
    // ************************************************************
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'hf;
        wdat <= {24'h0, d};
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) begin
            mismatches++;
            print_verdict();
        end
    endtask

    // Note the expected value, then read
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        expQ.push_back({24'h0, e});
        mskQ.push_back({24'h0, m});
        wb(1'b0, a, 8'h00);
    endtask

    task automatic cyc_wait(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Bounded wait for the converter to power down
    task automatic wait_idle();
        int n;
        n = 0;
        cyc_wait(3);
        while (power !== 1'b0 && n < 200) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 200) begin
            mismatches++;
            print_verdict();
        end
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [4:0]  codes[7];
        logic [11:0] a;
        logic [11:0] lo;
        logic [11:0] hi;
        logic [11:0] last;
        logic        ge;
        logic        want;
        int          s0;
        codes = '{5'h00, 5'h0f, 5'h10, 5'h1b, 5'h1c, 5'h1d, 5'h1e};
        cyc_wait(12);
        arst_n <= 1'b1;
        rd(adriv(0), 8'h1f, 8'hff);
        rd(4'h4, 8'h00, 8'hff);
        rd(4'h2, 8'h00, 8'hff);
        // Seven sample channel codes incl. reserved and references, single software conversion each
        foreach (codes[i]) begin
            res <= 12'($random(seed));
            s0 = starts;
            wb(1'b1, 4'h0, {3'b000, codes[i]});
            rd(4'h4, 8'h80, 8'h80);
            wait_idle();
            chk(starts - s0, 1);
            chk(asel, (codes[i] <= 5'h1b) ? codes[i] : 5'h00);
            chk({refHi, refLo}, {codes[i] == 5'h1d, codes[i] == 5'h1e});
            chk(irq, 0);
            rd(4'h0, {3'b100, codes[i]}, 8'hff);
            rd(4'h4, 8'h00, 8'h80);
            rd(4'hc, {4'h0, res[11:8]}, 8'h0f);
            rd(4'h8, res[7:0], 8'hff);
            rd(4'h0, 8'h00, 8'h80);
            last = res;
        end
        // Interrupt raised, then cleared by the low result read
        wb(1'b1, 4'h0, 8'h43);
        wait_idle();
        chk(irq, 1);
        rd(4'h8, last[7:0], 8'hff);
        cyc_wait(2);
        chk(irq, 0);
        // Abort and restart, then abort into off
        s0 = starts;
        wb(1'b1, 4'h0, 8'h04);
        cyc_wait(3);
        wb(1'b1, 4'h0, 8'h05);
        wait_idle();
        chk(starts - s0, 2);
        chk(asel, 5'h05);
        rd(4'hc, {4'h0, last[11:8]}, 8'h0f);
        rd(4'h8, last[7:0], 8'hff);
        wb(1'b1, 4'h0, 8'h04);
        cyc_wait(3);
        wb(1'b1, 4'h0, 8'h1f);
        cyc_wait(CLEN * 2);
        chk(starts - s0, 3);
        chk(power, 0);
        rd(4'h4, 8'h00, 8'h80);
        rd(4'h0, 8'h1f, 8'hff);
        // Compare in both senses, true and false
        for (int i = 0; i < 4; i++) begin
            ge = i[0];
            want = i[1];
            a = 12'($random(seed));
            lo = (a < (a ^ 12'h800)) ? a : (a ^ 12'h800);
            hi = lo ^ 12'h800;
            res <= (ge == want) ? hi : lo;
            cmpv <= (ge == want) ? lo : hi;
            wb(1'b1, 4'h4, {2'b00, 1'b1, ge, 4'h0});
            wb(1'b1, 4'h0, 8'h06);
            wait_idle();
            if (want) last = (ge == want) ? hi : lo;
            rd(4'h0, {want, 7'h06}, 8'hff);
            rd(4'hc, {4'h0, last[11:8]}, 8'h0f);
            rd(4'h8, last[7:0], 8'hff);
        end
        wb(1'b1, 4'h4, 8'h00);
        // Continuous software conversions, ended by the off code
        s0 = starts;
        wb(1'b1, 4'h0, 8'h22);
        cyc_wait(CLEN * 5);
        chk(starts - s0 >= 3, 1);
        wb(1'b1, 4'h0, 8'h1f);
        cyc_wait(2);
        s0 = starts;
        cyc_wait(CLEN * 4);
        chk(starts - s0, 0);
        chk(power, 0);
        // Hardware trigger: one start per rising edge only
        wb(1'b1, 4'h4, 8'h40);
        wb(1'b1, 4'h0, 8'h01);
        wait_idle();
        s0 = starts;
        cyc_wait(20);
        chk(starts - s0, 0);
        for (int k = 1; k <= 2; k++) begin
            trig <= 1'b1;
            cyc_wait(CLEN * 3);
            trig <= 1'b0;
            wait_idle();
            chk(starts - s0, k);
            rd(4'h0, 8'h81, 8'hff);
            rd(4'h8, res[7:0], 8'hff);
        end
        cyc_wait(4);
        chk(expQ.size(), 0);
        print_verdict();
    end

    function automatic logic [3:0] adriv(input int a);
        return 4'(a);
    endfunction
endmodule // adc_conversion_control_tb_top
